/* File: sbp_link_model.sv */
// link layer controller model: avalon-mm master reaching the phy registers
module sbp_link_model (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// avalon-mm master
	output logic [7:0]       address,
	output logic             read,
	output logic             write,
	output logic [3:0]       byteenable,
	output logic [31:0]      writedata,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest,
	// transmit gate
	input  wire logic        linkTxInhibit,
	output logic             txAllowed
);
	timeunit 1ns;
	timeprecision 1ps;

	// a misconfigured bus keeps the link silent
	assign txAllowed = resetn & ~linkTxInhibit;

	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'h0;
		writedata = 32'h0000_0000;
	end

	// no cycle limit here: only the bench watchdog ends a hung wait
	task automatic busWrite(input logic [7:0] addr, input logic [7:0] d);
		@(posedge core_clk);
		address <= addr;
		writedata <= {24'h00_0000, d};
		byteenable <= 4'hf;
		write <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask

	task automatic busRead(input logic [7:0] addr, output logic [31:0] d);
		@(posedge core_clk);
		address <= addr;
		byteenable <= 4'hf;
		read <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (waitrequest !== 1'b0);
		// data taken at the very edge that sees waitrequest low
		d = readdata;
		read <= 1'b0;
	endtask
endmodule

/* File: sbp_pkg.sv */
// register map, field layout, reset values and timing for the phy register bank
package sbp_pkg;

	// register indices; byte address on the bus is index times four
	localparam logic [3:0] REG_NODE     = 4'h0;
	localparam logic [3:0] REG_ROOTGAP  = 4'h1;
	localparam logic [3:0] REG_CAPS     = 4'h2;
	localparam logic [3:0] REG_SPEED    = 4'h3;
	localparam logic [3:0] REG_SELFID   = 4'h4;
	localparam logic [3:0] REG_EVENTS   = 4'h5;
	localparam logic [3:0] REG_WINSEL   = 4'h7;
	localparam logic [3:0] REG_PORTLINE = 4'h8;
	localparam logic [3:0] REG_PORTRATE = 4'h9;

	// field positions (bit 7 is the leftmost column)
	localparam int NODE_LSB     = 2;
	localparam int ROOT_BIT     = 1;
	localparam int POWER_BIT    = 0;
	localparam int HOLDOFF_BIT  = 7;
	localparam int FORCE_BIT    = 6;
	localparam int EXT_LSB      = 5;
	localparam int SPEED_LSB    = 5;
	localparam int LINKON_BIT   = 7;
	localparam int CONTEND_BIT  = 6;
	localparam int JITTER_LSB   = 3;
	localparam int RESUME_BIT   = 7;
	localparam int SHORT_BIT    = 6;
	localparam int LOOP_BIT     = 5;
	localparam int PWRLOST_BIT  = 4;
	localparam int TIMEOUT_BIT  = 3;
	localparam int PEVENT_BIT   = 2;
	localparam int ACCEL_BIT    = 1;
	localparam int MULTI_BIT    = 0;
	localparam int PAGE_LSB     = 5;
	localparam int ASTAT_LSB    = 6;
	localparam int BSTAT_LSB    = 4;
	localparam int CHILD_BIT    = 3;
	localparam int CONN_BIT     = 2;
	localparam int BIAS_BIT     = 1;
	localparam int DIS_BIT      = 0;
	localparam int RATE_LSB     = 5;
	localparam int INTEN_BIT    = 4;
	localparam int FAULT_BIT    = 3;

	// constants and reset values
	localparam logic [5:0] NODE_MISCONFIG = 6'h3f;
	localparam logic [5:0] GAP_RESET      = 6'h3f;
	localparam logic [2:0] EXT_CODE       = 3'h7;
	localparam logic [4:0] PORT_TOTAL     = 5'h03;
	localparam logic [2:0] MAX_SPEED      = 3'h2;
	localparam logic [3:0] DELAY_CODE     = 4'h0;
	localparam logic [2:0] JITTER_CODE    = 3'h0;
	localparam logic [2:0] PAGE_RESET     = 3'h0;
	localparam logic [3:0] PORTSEL_RESET  = 4'h0;
	localparam logic [2:0] PAGE_PORTSTAT  = 3'h0;
	localparam logic       LINKON_RESET   = 1'b1;
	localparam int         NUM_PORTS      = 3;

	// bus reset hold time
	localparam int CLK_PERIOD_NS  = 40;
	localparam int BUS_RESET_US   = 166;
	localparam int BUS_RESET_CYC  = (BUS_RESET_US * 1000) / CLK_PERIOD_NS;
	localparam int RESET_CNT_W    = 13;

	// live status of one cable port
	typedef struct packed {
		logic [1:0] lineA;
		logic [1:0] lineB;
		logic       child;
		logic       connected;
		logic       bias;
		logic [2:0] rate;
		logic       faultEvent;
		logic       resumeStart;
	} sbp_port_in_type;

	// self-id and arbitration controls handed to the core
	typedef struct packed {
		logic       linkBit;
		logic       contenderBit;
		logic [2:0] powerClass;
		logic       rootHoldoff;
		logic [5:0] gapSetting;
		logic       fastArb;
		logic       mixedSpeed;
	} sbp_ctrl_type;

endpackage

/* File: sbp_register_bank.sv */
// register bank of the three-port cable phy behind an avalon-mm slave
module sbp_register_bank #(
	parameter int BUS_RESET_CYCLES = sbp_pkg::BUS_RESET_CYC
) (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   resetn,
	// avalon-mm slave
	input  wire logic [7:0]             address,
	input  wire logic                   read,
	input  wire logic                   write,
	input  wire logic [3:0]             byteenable,
	input  wire logic [31:0]            writedata,
	output logic [31:0]                 readdata,
	output logic                        waitrequest,
	// status from the arbitration core
	input  wire logic [5:0]             nodeAddress,
	input  wire logic                   isRoot,
	input  wire logic                   cablePowerStatus,
	input  wire logic                   linkPowerStatus,
	input  wire logic                   loopDetected,
	input  wire logic                   arbTimeout,
	input  wire logic                   shortResetDone,
	input  wire sbp_pkg::sbp_port_in_type [2:0] portIn,
	// straps
	input  wire logic                   contenderStrapPin,
	input  wire logic [2:0]             powerStrapPins,
	// controls to the arbitration core
	output sbp_pkg::sbp_ctrl_type       ctrl,
	output logic                        busResetActive,
	output logic                        shortResetRequest,
	output logic                        linkTxInhibit,
	output logic [2:0]                  portDisabled
);

	typedef struct packed {
		logic                          waitReq;
		logic [31:0]                   rdData;
		logic                          strapDone;
		logic                          prevPower;
		logic                          rootHoldoff;
		logic                          forceReset;
		logic [sbp_pkg::RESET_CNT_W-1:0] resetCnt;
		logic [5:0]                    gap;
		logic                          linkOn;
		logic                          contender;
		logic [2:0]                    pwrClass;
		logic                          resumeEn;
		logic                          shortReq;
		logic                          loop;
		logic                          pwrLost;
		logic                          timeout;
		logic                          portEvent;
		logic                          accel;
		logic                          multi;
		logic [2:0]                    page;
		logic [3:0]                    portSel;
		logic [2:0]                    disabled;
		logic [2:0]                    intEn;
		logic [2:0]                    fault;
		logic [2:0]                    prevConn;
		logic [2:0]                    prevBias;
		logic [2:0]                    prevDis;
		logic [2:0]                    prevFault;
		logic                          selfIdL;
		logic                          txInhibit;
	} sbp_state_type;

	sbp_state_type st;
	sbp_state_type next_st;

	localparam logic [sbp_pkg::RESET_CNT_W-1:0] RESET_LAST =
		sbp_pkg::RESET_CNT_W'(BUS_RESET_CYCLES - 1);

	// write accepted to a given register index this cycle
	function automatic logic wrHit(input logic [3:0] idx);
		wrHit = write && !st.waitReq && byteenable[0]
			&& address[7:6] == 2'b00 && address[5:2] == idx;
	endfunction

	// per-port status byte fields, port index within range
	logic [2:0] portChange;
	logic       portValid;
	logic [1:0] portIdx;
	logic [7:0] regByte;
	logic [7:0] wd;
	logic       windowPort;

	assign wd = writedata[7:0];
	assign portIdx = st.portSel[1:0];
	assign portValid = st.portSel < 4'(sbp_pkg::NUM_PORTS);
	assign windowPort = st.page == sbp_pkg::PAGE_PORTSTAT && portValid;

	generate
		for (genvar p = 0; p < sbp_pkg::NUM_PORTS; p++) begin : g_change
			assign portChange[p] = st.intEn[p] &&
				(st.prevConn[p] != portIn[p].connected
				|| st.prevBias[p] != portIn[p].bias
				|| st.prevDis[p] != st.disabled[p]
				|| st.prevFault[p] != st.fault[p]);
		end
	endgenerate

	// read mux; reserved bits and unmapped addresses give zero
	always_comb begin
		regByte = 8'h00;
		if (address[7:6] != 2'b00) begin
			regByte = 8'h00;
		end else if (address[5:2] == sbp_pkg::REG_NODE) begin
			regByte[sbp_pkg::NODE_LSB +: 6] = nodeAddress;
			regByte[sbp_pkg::ROOT_BIT] = isRoot;
			regByte[sbp_pkg::POWER_BIT] = cablePowerStatus;
		end else if (address[5:2] == sbp_pkg::REG_ROOTGAP) begin
			regByte[sbp_pkg::HOLDOFF_BIT] = st.rootHoldoff;
			regByte[sbp_pkg::FORCE_BIT] = st.forceReset;
			regByte[5:0] = st.gap;
		end else if (address[5:2] == sbp_pkg::REG_CAPS) begin
			regByte[sbp_pkg::EXT_LSB +: 3] = sbp_pkg::EXT_CODE;
			regByte[4:0] = sbp_pkg::PORT_TOTAL;
		end else if (address[5:2] == sbp_pkg::REG_SPEED) begin
			regByte[sbp_pkg::SPEED_LSB +: 3] = sbp_pkg::MAX_SPEED;
			regByte[3:0] = sbp_pkg::DELAY_CODE;
		end else if (address[5:2] == sbp_pkg::REG_SELFID) begin
			regByte[sbp_pkg::LINKON_BIT] = st.linkOn;
			regByte[sbp_pkg::CONTEND_BIT] = st.contender;
			regByte[sbp_pkg::JITTER_LSB +: 3] = sbp_pkg::JITTER_CODE;
			regByte[2:0] = st.pwrClass;
		end else if (address[5:2] == sbp_pkg::REG_EVENTS) begin
			regByte[sbp_pkg::RESUME_BIT] = st.resumeEn;
			regByte[sbp_pkg::SHORT_BIT] = st.shortReq;
			regByte[sbp_pkg::LOOP_BIT] = st.loop;
			regByte[sbp_pkg::PWRLOST_BIT] = st.pwrLost;
			regByte[sbp_pkg::TIMEOUT_BIT] = st.timeout;
			regByte[sbp_pkg::PEVENT_BIT] = st.portEvent;
			regByte[sbp_pkg::ACCEL_BIT] = st.accel;
			regByte[sbp_pkg::MULTI_BIT] = st.multi;
		end else if (address[5:2] == sbp_pkg::REG_WINSEL) begin
			regByte[sbp_pkg::PAGE_LSB +: 3] = st.page;
			regByte[3:0] = st.portSel;
		end else if (address[5:2] == sbp_pkg::REG_PORTLINE) begin
			if (windowPort) begin
				regByte[sbp_pkg::ASTAT_LSB +: 2] = portIn[portIdx].lineA;
				regByte[sbp_pkg::BSTAT_LSB +: 2] = portIn[portIdx].lineB;
				regByte[sbp_pkg::CHILD_BIT] = portIn[portIdx].child;
				regByte[sbp_pkg::CONN_BIT] = portIn[portIdx].connected;
				regByte[sbp_pkg::BIAS_BIT] = portIn[portIdx].bias;
				regByte[sbp_pkg::DIS_BIT] = st.disabled[portIdx];
			end
		end else if (address[5:2] == sbp_pkg::REG_PORTRATE) begin
			if (windowPort) begin
				regByte[sbp_pkg::RATE_LSB +: 3] = portIn[portIdx].rate;
				regByte[sbp_pkg::INTEN_BIT] = st.intEn[portIdx];
				regByte[sbp_pkg::FAULT_BIT] = st.fault[portIdx];
			end
		end
	end

	always_comb begin
		next_st = st;
		// one wait cycle, then a single-cycle answer
		next_st.waitReq = !((read || write) && st.waitReq);
		if ((read || write) && st.waitReq) begin
			next_st.rdData = {24'h000000, regByte};
		end
		// straps caught on the first edge after reset release
		next_st.strapDone = 1'b1;
		if (!st.strapDone) begin
			next_st.contender = contenderStrapPin;
			next_st.pwrClass = powerStrapPins;
		end
		next_st.prevPower = cablePowerStatus;

		if (wrHit(sbp_pkg::REG_ROOTGAP)) begin
			next_st.rootHoldoff = wd[sbp_pkg::HOLDOFF_BIT];
			next_st.gap = wd[5:0];
		end
		// forced reset skips arbitration and runs for the full hold
		if (st.forceReset) begin
			next_st.resetCnt = st.resetCnt + 1'b1;
			if (st.resetCnt == RESET_LAST) begin
				next_st.forceReset = 1'b0;
				next_st.resetCnt = '0;
			end
		end else if (wrHit(sbp_pkg::REG_ROOTGAP)
				&& wd[sbp_pkg::FORCE_BIT]) begin
			next_st.forceReset = 1'b1;
			next_st.resetCnt = '0;
		end

		if (wrHit(sbp_pkg::REG_SELFID)) begin
			next_st.linkOn = wd[sbp_pkg::LINKON_BIT];
			next_st.contender = wd[sbp_pkg::CONTEND_BIT];
			next_st.pwrClass = wd[2:0];
		end

		// event register: clears first, hardware sets win after
		if (wrHit(sbp_pkg::REG_EVENTS)) begin
			next_st.resumeEn = wd[sbp_pkg::RESUME_BIT];
			next_st.accel = wd[sbp_pkg::ACCEL_BIT];
			next_st.multi = wd[sbp_pkg::MULTI_BIT];
			if (wd[sbp_pkg::SHORT_BIT]) begin
				next_st.shortReq = 1'b1;
			end
			if (wd[sbp_pkg::LOOP_BIT]) begin
				next_st.loop = 1'b0;
			end
			if (wd[sbp_pkg::PWRLOST_BIT]) begin
				next_st.pwrLost = 1'b0;
			end
			if (wd[sbp_pkg::TIMEOUT_BIT]) begin
				next_st.timeout = 1'b0;
			end
			if (wd[sbp_pkg::PEVENT_BIT]) begin
				next_st.portEvent = 1'b0;
			end
		end
		if (st.shortReq && shortResetDone) begin
			next_st.shortReq = 1'b0;
		end
		if (loopDetected) begin
			next_st.loop = 1'b1;
		end
		if (arbTimeout) begin
			next_st.timeout = 1'b1;
		end
		if (st.prevPower && !cablePowerStatus) begin
			next_st.pwrLost = 1'b1;
		end
		if (|portChange) begin
			next_st.portEvent = 1'b1;
		end
		for (int p = 0; p < sbp_pkg::NUM_PORTS; p++) begin
			if (st.resumeEn && portIn[p].resumeStart) begin
				next_st.portEvent = 1'b1;
			end
		end

		if (wrHit(sbp_pkg::REG_WINSEL)) begin
			next_st.page = wd[sbp_pkg::PAGE_LSB +: 3];
			next_st.portSel = wd[3:0];
		end
		for (int p = 0; p < sbp_pkg::NUM_PORTS; p++) begin
			if (wrHit(sbp_pkg::REG_PORTLINE) && windowPort
					&& portIdx == 2'(p)) begin
				next_st.disabled[p] = wd[sbp_pkg::DIS_BIT];
			end
			if (wrHit(sbp_pkg::REG_PORTRATE) && windowPort
					&& portIdx == 2'(p)) begin
				next_st.intEn[p] = wd[sbp_pkg::INTEN_BIT];
				if (wd[sbp_pkg::FAULT_BIT]) begin
					next_st.fault[p] = 1'b0;
				end
			end
			if (portIn[p].faultEvent) begin
				next_st.fault[p] = 1'b1;
			end
		end
		next_st.prevConn = {portIn[2].connected, portIn[1].connected,
			portIn[0].connected};
		next_st.prevBias = {portIn[2].bias, portIn[1].bias,
			portIn[0].bias};
		next_st.prevDis = st.disabled;
		next_st.prevFault = st.fault;
		next_st.selfIdL = st.linkOn && linkPowerStatus;
		next_st.txInhibit = nodeAddress == sbp_pkg::NODE_MISCONFIG;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.waitReq <= 1'b1;
			st.gap <= sbp_pkg::GAP_RESET;
			st.linkOn <= sbp_pkg::LINKON_RESET;
			st.page <= sbp_pkg::PAGE_RESET;
			st.portSel <= sbp_pkg::PORTSEL_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign readdata = st.rdData;
	assign waitrequest = st.waitReq;
	assign busResetActive = st.forceReset;
	assign shortResetRequest = st.shortReq;
	assign linkTxInhibit = st.txInhibit;
	assign portDisabled = st.disabled;
	assign ctrl = '{linkBit: st.selfIdL, contenderBit: st.contender,
		powerClass: st.pwrClass, rootHoldoff: st.rootHoldoff,
		gapSetting: st.gap, fastArb: st.accel, mixedSpeed: st.multi};

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// accepted writes as plain signals, so properties see sampled values
	logic rootGapWr;
	logic eventsWr;
	always_comb begin
		rootGapWr = wrHit(sbp_pkg::REG_ROOTGAP);
		eventsWr = wrHit(sbp_pkg::REG_EVENTS);
	end

	sequence evtClearWrite;
		eventsWr && wd[sbp_pkg::PWRLOST_BIT]
			&& !(st.prevPower && !cablePowerStatus);
	endsequence
	sequence powerFall;
		st.prevPower && !cablePowerStatus;
	endsequence

	// helper: cycles that the forced reset has stood
	logic [sbp_pkg::RESET_CNT_W:0] holdCnt;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			holdCnt <= '0;
		end else if (busResetActive) begin
			holdCnt <= holdCnt + 1'b1;
		end else begin
			holdCnt <= '0;
		end
	end

	answer_one_cycle_a: assert property ((read || write) && waitrequest
		|=> !waitrequest ##1 waitrequest)
		else $error("slave answer not one cycle");
	force_reset_len_a: assert property ($fell(busResetActive)
		|-> holdCnt == (sbp_pkg::RESET_CNT_W + 1)'(BUS_RESET_CYCLES))
		else $error("bus reset hold length wrong");
	force_reset_start_a: assert property (rootGapWr
		&& wd[sbp_pkg::FORCE_BIT] && !busResetActive
		|=> busResetActive [*2])
		else $error("forced reset did not start");
	power_lost_set_a: assert property (powerFall |=> st.pwrLost)
		else $error("power loss not flagged");
	power_lost_clr_a: assert property (evtClearWrite
		|=> !st.pwrLost)
		else $error("power lost flag not cleared");
	link_bit_and_a: assert property ($past(resetn) |-> ctrl.linkBit
		== $past(st.linkOn && linkPowerStatus))
		else $error("self-id L bit wrong");
	misconfig_block_a: assert property (nodeAddress
		== sbp_pkg::NODE_MISCONFIG |=> linkTxInhibit)
		else $error("node 63 did not block link");
	strap_capture_a: assert property ($rose(st.strapDone)
		|-> ctrl.contenderBit == $past(contenderStrapPin)
		&& ctrl.powerClass == $past(powerStrapPins))
		else $error("straps not captured");
	short_req_hold_a: assert property (shortResetRequest
		&& !shortResetDone |=> shortResetRequest)
		else $error("short reset request dropped early");
	port_event_set_a: assert property (|portChange |=> st.portEvent)
		else $error("port change not flagged");
	fault_set_a: assert property (portIn[0].faultEvent
		|=> st.fault[0])
		else $error("port fault not flagged");

endmodule

/* File: tb_sbp_register_bank.sv */
// self-checking bench for the phy register bank
module tb_sbp_register_bank;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int HOLD = 20;

	logic                           core_clk;
	logic                           resetn;
	logic [7:0]                     address;
	logic                           read;
	logic                           write;
	logic [3:0]                     byteenable;
	logic [31:0]                    writedata;
	logic [31:0]                    readdata;
	logic                           waitrequest;
	logic [5:0]                     nodeAddress;
	logic                           isRoot;
	logic                           cablePowerStatus;
	logic                           linkPowerStatus;
	logic                           loopDetected;
	logic                           arbTimeout;
	logic                           shortResetDone;
	sbp_pkg::sbp_port_in_type [2:0] portIn;
	logic                           contenderStrapPin;
	logic [2:0]                     powerStrapPins;
	sbp_pkg::sbp_ctrl_type          ctrl;
	logic                           busResetActive;
	logic                           shortResetRequest;
	logic                           linkTxInhibit;
	logic [2:0]                     portDisabled;
	logic                           txAllowed;
	int                             nErrors = 0;
	int                             checkCount = 0;
	int                             resetCycles = 0;

	sbp_register_bank #(.BUS_RESET_CYCLES(HOLD)) i_dut (
		.core_clk(core_clk), .resetn(resetn), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .nodeAddress(nodeAddress),
		.isRoot(isRoot), .cablePowerStatus(cablePowerStatus),
		.linkPowerStatus(linkPowerStatus), .loopDetected(loopDetected),
		.arbTimeout(arbTimeout), .shortResetDone(shortResetDone),
		.portIn(portIn), .contenderStrapPin(contenderStrapPin),
		.powerStrapPins(powerStrapPins), .ctrl(ctrl),
		.busResetActive(busResetActive),
		.shortResetRequest(shortResetRequest),
		.linkTxInhibit(linkTxInhibit), .portDisabled(portDisabled)
	);

	sbp_link_model i_link (
		.core_clk(core_clk), .resetn(resetn), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .linkTxInhibit(linkTxInhibit),
		.txAllowed(txAllowed)
	);

	always #20 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		if (busResetActive === 1'b1)
			resetCycles <= resetCycles + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
		logic [31:0] v;
		i_link.busRead({2'b00, idx, 2'b00}, v);
		check(v, {24'h00_0000, exp});
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		i_link.busWrite({2'b00, idx, 2'b00}, d);
	endtask

	task automatic waitClk(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		logic [31:0] v;
		core_clk = 1'b0;
		resetn = 1'b0;
		nodeAddress = 6'h15;
		isRoot = 1'b1;
		cablePowerStatus = 1'b1;
		linkPowerStatus = 1'b1;
		loopDetected = 1'b0;
		arbTimeout = 1'b0;
		shortResetDone = 1'b0;
		portIn = '0;
		contenderStrapPin = 1'b1;
		powerStrapPins = 3'h5;
		waitClk(3);
		resetn <= 1'b1;
		// reset values and constants
		rd(4'h1, 8'h3f);
		rd(4'h2, 8'he3);
		rd(4'h3, 8'h40);
		rd(4'h4, 8'hc5);
		rd(4'h5, 8'h00);
		rd(4'h7, 8'h00);
		rd(4'h6, 8'h00);
		i_link.busRead(8'h40, v);
		check(v, 32'h0000_0000);
		rd(4'h0, 8'h57);
		check(linkTxInhibit, 1'b0);
		check(ctrl.linkBit, 1'b1);
		nodeAddress <= 6'h3f;
		waitClk(3);
		check(linkTxInhibit, 1'b1);
		check(txAllowed, 1'b0);
		// self-id controls
		wr(4'h4, 8'h02);
		rd(4'h4, 8'h02);
		check(ctrl.linkBit, 1'b0);
		check(ctrl.contenderBit, 1'b0);
		check(ctrl.powerClass, 3'h2);
		wr(4'h4, 8'hff);
		rd(4'h4, 8'hc7);
		linkPowerStatus <= 1'b0;
		waitClk(3);
		check(ctrl.linkBit, 1'b0);
		// holdoff and gap
		wr(4'h1, 8'h95);
		rd(4'h1, 8'h95);
		check(ctrl.rootHoldoff, 1'b1);
		check(ctrl.gapSetting, 6'h15);
		// forced bus reset
		wr(4'h1, 8'h55);
		rd(4'h1, 8'h55);
		waitClk(HOLD + 5);
		rd(4'h1, 8'h15);
		check(resetCycles, HOLD);
		// short reset request
		wr(4'h5, 8'h40);
		rd(4'h5, 8'h40);
		check(shortResetRequest, 1'b1);
		shortResetDone <= 1'b1;
		waitClk(1);
		shortResetDone <= 1'b0;
		waitClk(2);
		rd(4'h5, 8'h00);
		check(shortResetRequest, 1'b0);
		// event flags, write one to clear
		loopDetected <= 1'b1;
		arbTimeout <= 1'b1;
		cablePowerStatus <= 1'b0;
		waitClk(1);
		loopDetected <= 1'b0;
		arbTimeout <= 1'b0;
		waitClk(3);
		rd(4'h5, 8'h38);
		wr(4'h5, 8'h38);
		rd(4'h5, 8'h00);
		// enables and resume event
		wr(4'h5, 8'h83);
		rd(4'h5, 8'h83);
		check(ctrl.fastArb, 1'b1);
		check(ctrl.mixedSpeed, 1'b1);
		portIn[1].resumeStart <= 1'b1;
		waitClk(1);
		portIn[1].resumeStart <= 1'b0;
		waitClk(4);
		rd(4'h5, 8'h87);
		wr(4'h5, 8'h87);
		rd(4'h5, 8'h83);
		// port status window, port 1
		portIn[1].lineA <= 2'b01;
		portIn[1].lineB <= 2'b10;
		portIn[1].child <= 1'b1;
		portIn[1].bias <= 1'b1;
		portIn[1].rate <= 3'h2;
		wr(4'h7, 8'h01);
		rd(4'h7, 8'h01);
		rd(4'h8, 8'h6a);
		rd(4'h9, 8'h40);
		waitClk(3);
		rd(4'h5, 8'h83);
		wr(4'h9, 8'h10);
		rd(4'h9, 8'h50);
		portIn[1].connected <= 1'b1;
		waitClk(4);
		rd(4'h5, 8'h87);
		wr(4'h5, 8'h87);
		rd(4'h8, 8'h6e);
		portIn[0].faultEvent <= 1'b1;
		portIn[1].faultEvent <= 1'b1;
		waitClk(1);
		portIn[0].faultEvent <= 1'b0;
		portIn[1].faultEvent <= 1'b0;
		waitClk(3);
		rd(4'h9, 8'h58);
		wr(4'h9, 8'h18);
		rd(4'h9, 8'h50);
		wr(4'h8, 8'h01);
		rd(4'h8, 8'h6f);
		check(portDisabled, 3'b010);
		rd(4'ha, 8'h00);
		// other pages and an absent port show an empty window
		wr(4'h7, 8'h21);
		rd(4'h8, 8'h00);
		wr(4'h7, 8'h03);
		rd(4'h8, 8'h00);
		results();
	end

	initial begin
		waitClk(5000);
		nErrors++;
		results();
	end
endmodule
